// [core/lpc_ctrl.sv]
// Low-power mode controller: operating mode, clock dividers, sleep and standby sequencing.
// Assumes interrupt and reset request inputs are asynchronous pins; a Wishbone master on clk.
// Functional notes
// - Software selects one of five operating power modes, each allowing a set of clock sources (all six in the high and middle modes).
// - Core, peripheral and bus clock enables are divided from the selected source by programmed ratios.
// - Four low-power modes exist: sleep, software standby, deep standby and snooze.
// - Sleep halts the core and bus clocks while the peripherals keep running.
// - Sleep ends on any interrupt or any reset request.
// - Software standby gates core, peripherals and oscillators while retention stays on.
// - Software standby ends on interrupts enabled in the wake-up enable register or on any reset request.
// - Deep standby also stops oscillators and memory and removes core power.
// - Snooze runs selected peripherals from standby without waking the core.
// - Snooze is entered only from standby on snooze triggers and left on standby wake sources.
// - Every peripheral has its own module-stop bit, whatever the power mode.
module lpc_ctrl
    import lpc_pkg::*;
(
    input  wire logic                       clk,
    input  wire logic                       rst_n,
    input  wire logic [lpc_pkg::ADDR_W-1:0] wb_adr_i,
    input  wire logic [31:0]                wb_dat_i,
    output logic      [31:0]                wb_dat_o,
    input  wire logic [3:0]                 wb_sel_i,
    input  wire logic                       wb_we_i,
    input  wire logic                       wb_cyc_i,
    input  wire logic                       wb_stb_i,
    output logic                            wb_ack_o,
    input  wire logic                       sleep_request,
    input  wire logic [lpc_pkg::NUM_IRQ-1:0] irq_in,
    input  wire logic [lpc_pkg::NUM_RST-1:0] reset_request,
    output logic                            system_core_clock_en,
    output logic                            peripheral_clock_b_en,
    output logic                            peripheral_clock_d_en,
    output logic                            bus_clock_en,
    output logic [lpc_pkg::NUM_MOD-1:0]     module_run,
    output logic [lpc_pkg::NUM_SRC-1:0]     osc_enable,
    output logic                            core_power_on,
    output logic                            memory_power_on,
    output logic                            io_hold,
    output logic                            irq_o
);
    import lpc_pkg::*;

    function automatic logic [5:0] src_allowed(input logic [2:0] pm);
        case (pm)
            PM_HIGH: src_allowed = SRC_OK_HIGH;
            PM_MID:  src_allowed = SRC_OK_MID;
            PM_LV:   src_allowed = SRC_OK_LV;
            PM_LOW:  src_allowed = SRC_OK_LOW;
            PM_SUB:  src_allowed = SRC_OK_SUB;
            default: src_allowed = 6'h00;
        endcase
    endfunction

    function automatic logic div_tick(input logic [DIV_W-1:0] cnt, input logic [DIV_W-1:0] ratio);
        div_tick = (cnt == ratio);
    endfunction

    // Two-flop synchronisers for the pin inputs.
    logic [NUM_IRQ-1:0] irq_s1_reg, irq_s2_reg;
    logic [NUM_RST-1:0] rst_s1_reg, rst_s2_reg;
    logic               slp_s1_reg, slp_s2_reg;

    always_ff @(posedge clk) begin
        irq_s1_reg <= irq_in;
        irq_s2_reg <= irq_s1_reg;
        rst_s1_reg <= reset_request;
        rst_s2_reg <= rst_s1_reg;
        slp_s1_reg <= sleep_request;
        slp_s2_reg <= slp_s1_reg;
    end

    // Software-visible registers.
    logic [2:0]          pmode_reg;
    logic [2:0]          src_reg;
    logic [11:0]         div_reg;
    logic [1:0]          lpsel_reg;
    logic [NUM_IRQ-1:0]  wake_en_reg;
    logic [NUM_IRQ-1:0]  snzen_reg;
    logic [NUM_MOD-1:0]  mstop_reg;
    logic [NUM_EV-1:0]   stat_reg, stat_next;
    logic [NUM_EV-1:0]   mask_reg;
    lpc_state_t          state_reg, state_next;
    logic                ack_reg;
    logic [31:0]         rdata_reg;

    wire       req        = wb_cyc_i & wb_stb_i & ~ack_reg;
    wire       wr         = req & wb_we_i & wb_sel_i[0];
    wire       wr_pm      = wr & (wb_adr_i == OFF_PWRMODE);
    wire       wr_div     = wr & (wb_adr_i == OFF_DIV);
    wire       wr_lp      = wr & (wb_adr_i == OFF_LPCTRL);
    wire       wr_wake    = wr & (wb_adr_i == OFF_WAKE_EN);
    wire       wr_snooze  = wr & (wb_adr_i == OFF_SNOOZE_EN);
    wire       wr_ms      = wr & (wb_adr_i == OFF_MSTOP);
    wire       wr_st      = wr & (wb_adr_i == OFF_IRQ_STAT);
    wire       wr_mk      = wr & (wb_adr_i == OFF_IRQ_MASK);
    wire [5:0] new_ok     = src_allowed(wb_dat_i[2:0]);
    wire       src_fits   = new_ok[wb_dat_i[6:4]];
    wire       pm_valid   = (wb_dat_i[2:0] <= PM_SUB) && (wb_dat_i[6:4] < 3'(NUM_SRC)) && src_fits;
    wire       lp_valid   = (wb_dat_i[1:0] != 2'b11) && (HAS_DEEP || wb_dat_i[1:0] != LP_DEEP);
    wire       lp_enter   = wr_lp & wb_dat_i[8] & lp_valid & (state_reg == ST_NORMAL);
    wire       any_irq    = |irq_s2_reg;
    wire       any_rst    = |rst_s2_reg;
    wire       wake_stby  = |(irq_s2_reg & wake_en_reg) | any_rst;
    // A snooze trigger is an enabled snooze source that is not also a wake source.
    wire       snooze_go  = |(irq_s2_reg & snzen_reg & ~wake_en_reg);
    wire       slp_enter  = slp_s2_reg & (state_reg == ST_NORMAL);

    logic [31:0] rdata_mux;
    always_comb begin
        rdata_mux = 32'h0;
        if (wb_adr_i == OFF_PWRMODE) begin
            rdata_mux = {25'h0, src_reg, 1'b0, pmode_reg};
        end else if (wb_adr_i == OFF_DIV) begin
            rdata_mux = {20'h0, div_reg};
        end else if (wb_adr_i == OFF_LPCTRL) begin
            rdata_mux = {30'h0, lpsel_reg};
        end else if (wb_adr_i == OFF_WAKE_EN) begin
            rdata_mux = {16'h0, wake_en_reg};
        end else if (wb_adr_i == OFF_SNOOZE_EN) begin
            rdata_mux = {16'h0, snzen_reg};
        end else if (wb_adr_i == OFF_MSTOP) begin
            rdata_mux = {16'h0, mstop_reg};
        end else if (wb_adr_i == OFF_STATE) begin
            rdata_mux = {29'h0, state_reg};
        end else if (wb_adr_i == OFF_IRQ_STAT) begin
            rdata_mux = {28'h0, stat_reg};
        end else if (wb_adr_i == OFF_IRQ_MASK) begin
            rdata_mux = {28'h0, mask_reg};
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ack_reg   <= 1'b0;
            rdata_reg <= 32'h0;
        end else begin
            ack_reg   <= req;
            rdata_reg <= req ? rdata_mux : rdata_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pmode_reg <= PM_RESET;
            src_reg   <= SRC_RESET;
            div_reg   <= DIV_RESET;
            lpsel_reg <= LP_SLEEP;
            wake_en_reg <= '0;
            snzen_reg <= '0;
            mstop_reg <= '0;
            mask_reg  <= '0;
        end else begin
            if (wr_pm && pm_valid) begin
                pmode_reg <= wb_dat_i[2:0];
                src_reg   <= wb_dat_i[6:4];
            end
            if (wr_div) begin
                div_reg <= wb_dat_i[11:0];
            end
            if (wr_lp && lp_valid) begin
                lpsel_reg <= wb_dat_i[1:0];
            end
            if (wr_wake) begin
                wake_en_reg <= wb_dat_i[NUM_IRQ-1:0];
            end
            if (wr_snooze) begin
                snzen_reg <= wb_dat_i[NUM_IRQ-1:0];
            end
            if (wr_ms) begin
                mstop_reg <= wb_dat_i[NUM_MOD-1:0];
            end
            if (wr_mk) begin
                mask_reg <= wb_dat_i[NUM_EV-1:0];
            end
        end
    end

    // Low-power state machine.
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_NORMAL: begin
                if (lp_enter || slp_enter) begin
                    case (slp_enter ? LP_SLEEP : lpc_lpsel_t'(wb_dat_i[1:0]))
                        LP_STBY: state_next = ST_STBY;
                        LP_DEEP: state_next = ST_DEEP;
                        default: state_next = ST_SLEEP;
                    endcase
                end
            end
            ST_SLEEP: begin
                if (any_irq || any_rst) begin
                    state_next = ST_RESTART;
                end
            end
            ST_STBY: begin
                if (wake_stby) begin
                    state_next = ST_RESTART;
                end else if (snooze_go) begin
                    state_next = ST_SNOOZE;
                end
            end
            ST_SNOOZE: begin
                if (wake_stby) begin
                    state_next = ST_RESTART;
                end else if (!snooze_go) begin
                    state_next = ST_STBY;
                end
            end
            ST_DEEP: begin
                if (wake_stby) begin
                    state_next = ST_RESTART;
                end
            end
            default: state_next = ST_NORMAL;
        endcase
    end

    wire ev_wake = (state_next == ST_RESTART) && (state_reg != ST_RESTART);
    wire ev_sin  = (state_next == ST_SNOOZE) && (state_reg == ST_STBY);
    wire ev_sout = (state_reg == ST_SNOOZE) && (state_next != ST_SNOOZE);
    wire ev_bad  = (wr_pm && !pm_valid) || (wr_lp && !lp_valid);

    // An event in the same cycle as a write-one-to-clear wins, so no event is lost.
    always_comb begin
        stat_next = stat_reg & ~(wr_st ? wb_dat_i[NUM_EV-1:0] : '0);
        stat_next[EV_WAKE]       = stat_next[EV_WAKE] | ev_wake;
        stat_next[EV_SNOOZE_IN]  = stat_next[EV_SNOOZE_IN] | ev_sin;
        stat_next[EV_SNOOZE_OUT] = stat_next[EV_SNOOZE_OUT] | ev_sout;
        stat_next[EV_BAD_MODE]  = stat_next[EV_BAD_MODE] | ev_bad;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_reg <= ST_NORMAL;
            stat_reg  <= '0;
        end else begin
            state_reg <= state_next;
            stat_reg  <= stat_next;
        end
    end

    // Clock dividers: each counter wraps at its ratio and gives a one-cycle enable.
    logic [DIV_W-1:0] cnt_core_reg, cnt_pb_reg, cnt_pd_reg;
    wire tick_core = div_tick(cnt_core_reg, div_reg[3:0]);
    wire tick_pb   = div_tick(cnt_pb_reg, div_reg[7:4]);
    wire tick_pd   = div_tick(cnt_pd_reg, div_reg[11:8]);

    always_ff @(posedge clk) begin
        if (!rst_n || state_reg == ST_RESTART) begin
            cnt_core_reg <= '0;
            cnt_pb_reg   <= '0;
            cnt_pd_reg   <= '0;
        end else begin
            cnt_core_reg <= tick_core ? '0 : cnt_core_reg + 1'b1;
            cnt_pb_reg   <= tick_pb ? '0 : cnt_pb_reg + 1'b1;
            cnt_pd_reg   <= tick_pd ? '0 : cnt_pd_reg + 1'b1;
        end
    end

    wire run_core   = (state_reg == ST_NORMAL);
    wire run_periph = (state_reg == ST_NORMAL) || (state_reg == ST_SLEEP);
    wire powered    = (state_reg != ST_DEEP);
    wire standby    = (state_reg == ST_STBY) || (state_reg == ST_SNOOZE) || (state_reg == ST_DEEP);
    wire [5:0] osc_sel = 6'(1) << src_reg;
    wire [5:0] osc_next = (run_periph || state_reg == ST_SNOOZE || state_reg == ST_RESTART)
                          ? (osc_sel & src_allowed(pmode_reg)) : 6'h00;
    // In snooze only peripherals enabled for it and not stopped keep running.
    wire [NUM_MOD-1:0] mod_next = ~mstop_reg & (run_periph ? {NUM_MOD{1'b1}}
                                  : (state_reg == ST_SNOOZE ? snzen_reg[NUM_MOD-1:0] : '0));

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            system_core_clock_en  <= 1'b0;
            peripheral_clock_b_en <= 1'b0;
            peripheral_clock_d_en <= 1'b0;
            bus_clock_en          <= 1'b0;
            module_run            <= '0;
            osc_enable            <= '0;
            core_power_on         <= 1'b1;
            memory_power_on       <= 1'b1;
            io_hold               <= 1'b0;
            irq_o                 <= 1'b0;
        end else begin
            system_core_clock_en  <= run_core & tick_core;
            peripheral_clock_b_en <= (run_periph | state_reg == ST_SNOOZE) & tick_pb;
            peripheral_clock_d_en <= run_periph & tick_pd;
            bus_clock_en          <= run_core & tick_core;
            module_run            <= mod_next;
            osc_enable            <= osc_next;
            core_power_on         <= powered;
            memory_power_on       <= powered;
            io_hold               <= standby;
            irq_o                 <= |(stat_next & mask_reg);
        end
    end

    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;
endmodule

// [core/lpc_pkg.sv]
// Constants shared by the low-power mode controller.
// Assumes a single 10 MHz clock and a classic Wishbone slave port with 32-bit data.
package lpc_pkg;
    localparam int          ADDR_W          = 8;
    localparam logic [7:0]  OFF_PWRMODE     = 8'h00;
    localparam logic [7:0]  OFF_DIV         = 8'h04;
    localparam logic [7:0]  OFF_LPCTRL      = 8'h08;
    localparam logic [7:0]  OFF_WAKE_EN     = 8'h0c;
    localparam logic [7:0]  OFF_SNOOZE_EN   = 8'h10;
    localparam logic [7:0]  OFF_MSTOP       = 8'h14;
    localparam logic [7:0]  OFF_STATE       = 8'h18;
    localparam logic [7:0]  OFF_IRQ_STAT    = 8'h1c;
    localparam logic [7:0]  OFF_IRQ_MASK    = 8'h20;
    localparam int          NUM_IRQ         = 16;
    localparam int          NUM_MOD         = 16;
    localparam int          NUM_RST         = 6;
    localparam int          DIV_W           = 4;
    // Operating power modes: bit mask of clock sources allowed in each mode.
    // Source bits: 0 pll, 1 hoco, 2 moco, 3 loco, 4 main osc, 5 sub osc.
    localparam int          NUM_SRC         = 6;
    localparam logic [2:0]  SRC_RESET       = 3'h2;
    localparam logic [5:0]  SRC_OK_HIGH     = 6'h3f;
    localparam logic [5:0]  SRC_OK_MID      = 6'h3f;
    localparam logic [5:0]  SRC_OK_LV       = 6'h3e;
    localparam logic [5:0]  SRC_OK_LOW      = 6'h3e;
    localparam logic [5:0]  SRC_OK_SUB      = 6'h28;
    localparam logic [2:0]  PM_RESET        = 3'h1;
    localparam logic [11:0] DIV_RESET       = 12'h000;
    localparam int          EV_WAKE         = 0;
    localparam int          EV_SNOOZE_IN    = 1;
    localparam int          EV_SNOOZE_OUT   = 2;
    localparam int          EV_BAD_MODE     = 3;
    localparam int          NUM_EV          = 4;
    localparam logic        HAS_DEEP        = 1'b1;

    typedef enum logic [2:0] {
        PM_HIGH = 3'b000,
        PM_MID  = 3'b001,
        PM_LV   = 3'b010,
        PM_LOW  = 3'b011,
        PM_SUB  = 3'b100
    } lpc_pmode_t;

    typedef enum logic [1:0] {
        LP_SLEEP = 2'b00,
        LP_STBY  = 2'b01,
        LP_DEEP  = 2'b10
    } lpc_lpsel_t;

    typedef enum logic [2:0] {
        ST_NORMAL  = 3'b000,
        ST_SLEEP   = 3'b001,
        ST_STBY    = 3'b010,
        ST_DEEP    = 3'b011,
        ST_SNOOZE  = 3'b100,
        ST_RESTART = 3'b101
    } lpc_state_t;
endpackage

// [sim/lpc_ctrl_checker.sv]
// Concurrent checks on the ports of the low-power mode controller.
// Assumes it is bound to lpc_ctrl and sees only that module's ports.
module lpc_ctrl_checker
    import lpc_pkg::*;
(
    input wire logic                        clk,
    input wire logic                        rst_n,
    input wire logic                        wb_cyc_i,
    input wire logic                        wb_stb_i,
    input wire logic                        wb_ack_o,
    input wire logic [lpc_pkg::NUM_RST-1:0] reset_request,
    input wire logic                        system_core_clock_en,
    input wire logic [lpc_pkg::NUM_SRC-1:0] osc_enable,
    input wire logic                        core_power_on,
    input wire logic                        memory_power_on,
    input wire logic                        io_hold,
    input wire logic                        irq_o
);
    import lpc_pkg::*;
    property p_ack_once;
        @(posedge clk) disable iff (!rst_n) wb_ack_o |=> !wb_ack_o;
    endproperty
    property p_ack_latency;
        @(posedge clk) disable iff (!rst_n) (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o;
    endproperty
    property p_osc_single;
        @(posedge clk) disable iff (!rst_n) $countones(osc_enable) <= 1;
    endproperty
    property p_deep_off;
        @(posedge clk) disable iff (!rst_n) !core_power_on |-> (io_hold && osc_enable == '0);
    endproperty
    property p_power_pair;
        @(posedge clk) disable iff (!rst_n) core_power_on == memory_power_on;
    endproperty
    property p_standby_gate;
        @(posedge clk) disable iff (!rst_n) (io_hold && $past(io_hold)) |-> !system_core_clock_en;
    endproperty
    property p_reset_wake;
        @(posedge clk) disable iff (!rst_n) (|reset_request) [*4] |-> ##[0:6] !io_hold;
    endproperty
    property p_reset_values;
        @(posedge clk) !rst_n |=> (!wb_ack_o && !irq_o && core_power_on && !io_hold);
    endproperty
    a_ack_once: assert property (p_ack_once) else $error("ack longer than one cycle");
    a_ack_latency: assert property (p_ack_latency) else $error("ack missing one cycle after request");
    a_osc_single: assert property (p_osc_single) else $error("more than one source enabled");
    a_deep_off: assert property (p_deep_off) else $error("core power off outside deep standby");
    a_power_pair: assert property (p_power_pair) else $error("core and memory power differ");
    a_standby_gate: assert property (p_standby_gate) else $error("core clock runs in standby");
    a_reset_wake: assert property (p_reset_wake) else $error("reset request did not wake");
    a_reset_values: assert property (p_reset_values) else $error("outputs wrong after reset");
    c_standby: cover property (@(posedge clk) $rose(io_hold));
    c_deep: cover property (@(posedge clk) $fell(core_power_on));
    c_irq: cover property (@(posedge clk) $rose(irq_o));
endmodule

// [sim/tb.sv]
// Self-checking bench for the low-power mode controller.
// Assumes a 10 MHz clock; register reads are checked by a monitor against a queue.
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import lpc_pkg::*;
    logic        clk, rst_n, cyc, stb, we, sleep_req, wb_ack_o, irq_o;
    logic        core_en, pb_en, pd_en, bus_en, core_pwr, mem_pwr, io_hold;
    logic [7:0]  adr;
    logic [31:0] dat, wb_dat_o, r;
    logic [3:0]  sel;
    logic [15:0] irq, module_run, v;
    logic [5:0]  rrq, osc_enable;
    logic [6:0]  prev, pm;
    logic [5:0]  okt [5];
    int          mismatches, tests_run, cycles, c, cp, cd;
    logic [31:0] exp_q [$];
    lpc_ctrl uut (.clk(clk), .rst_n(rst_n), .wb_adr_i(adr), .wb_dat_i(dat), .wb_dat_o(wb_dat_o),
        .wb_sel_i(sel), .wb_we_i(we), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_ack_o(wb_ack_o),
        .sleep_request(sleep_req), .irq_in(irq), .reset_request(rrq), .system_core_clock_en(core_en),
        .peripheral_clock_b_en(pb_en), .peripheral_clock_d_en(pd_en), .bus_clock_en(bus_en),
        .module_run(module_run), .osc_enable(osc_enable), .core_power_on(core_pwr),
        .memory_power_on(mem_pwr), .io_hold(io_hold), .irq_o(irq_o));
    task wrap_up;
        $display("Comparisons: %0d, mismatches: %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] e);
        tests_run++;
        if (got !== e) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, e);
        end
    endtask
    task wb(input logic [7:0] a, input logic [31:0] d, input logic w, input logic [31:0] e);
        int n;
        @(posedge clk);
        cyc <= 1'b1; stb <= 1'b1; adr <= a; dat <= d; we <= w;
        if (!w) exp_q.push_back(e);
        n = 0;
        do begin @(posedge clk); n++; end while (wb_ack_o !== 1'b1 && n < 20);
        if (n >= 20) begin mismatches++; wrap_up(); end
        cyc <= 1'b0; stb <= 1'b0;
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d); wb(a, d, 1'b1, 32'h0); endtask
    task rd(input logic [7:0] a, input logic [31:0] e); wb(a, 32'h0, 1'b0, e); endtask
    task wt(input int n); repeat (n) @(posedge clk); endtask
    // Measures the spacing of two core clock pulses.
    task period(input int e);
        int n;
        n = 0;
        do begin @(posedge clk); n++; end while (core_en !== 1'b1 && n < 40);
        chk(32'(bus_en), 32'h1);
        n = 0;
        do begin @(posedge clk); n++; end while (core_en !== 1'b1 && n < 40);
        chk(n, e);
    endtask
    // Counts pulses over 40 cycles: core and bus stay off, the peripheral clocks run as told.
    task ncore(input logic pb_on, input logic pd_on);
        c = 0;
        cp = 0;
        cd = 0;
        repeat (40) begin
            @(posedge clk);
            if (core_en === 1'b1 || bus_en === 1'b1) c++;
            if (pb_en === 1'b1) cp++;
            if (pd_en === 1'b1) cd++;
        end
        chk(c, 0);
        chk(32'(cp > 0), 32'(pb_on));
        chk(32'(cd > 0), 32'(pd_on));
    endtask
    initial begin clk = 1'b0; forever #50 clk = ~clk; end
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin mismatches++; wrap_up(); end
        if (rst_n === 1'b1 && wb_ack_o === 1'b1 && !we) chk(wb_dat_o, exp_q.pop_front());
    end
    initial begin
        rst_n = 1'b0; cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = '0; dat = '0; sel = 4'hf;
        sleep_req = 1'b0; irq = '0; rrq = '0;
        okt = '{SRC_OK_HIGH, SRC_OK_MID, SRC_OK_LV, SRC_OK_LOW, SRC_OK_SUB};
        r = $urandom(32'h5866);
        wt(3); rst_n <= 1'b1;
        prev = {SRC_RESET, 1'b0, PM_RESET};
        rd(OFF_PWRMODE, 32'(prev));
        rd(OFF_DIV, 32'(DIV_RESET));
        rd(OFF_STATE, 32'h0);
        rd(8'hfc, 32'h0);
        chk(32'(module_run), 32'hffff);
        for (int m = 0; m < 5; m++) for (int s = 0; s < 6; s++) begin
            pm = {3'(s), 1'b0, 3'(m)};
            wr(OFF_PWRMODE, 32'(pm));
            if (okt[m][s]) prev = pm;
            rd(OFF_PWRMODE, 32'(prev));
            chk(32'(osc_enable), 32'h1 << prev[6:4]);
        end
        wr(OFF_PWRMODE, 32'({SRC_RESET, 1'b0, PM_RESET}));
        wr(OFF_IRQ_MASK, 32'h8); wt(2);
        chk(32'(irq_o), 32'h1);
        rd(OFF_IRQ_STAT, 32'h8);
        wr(OFF_IRQ_STAT, 32'hf); wt(2);
        chk(32'(irq_o), 32'h0);
        wr(OFF_LPCTRL, 32'h103); wt(2);
        rd(OFF_STATE, 32'h0);
        chk(32'(irq_o), 32'h1);
        wr(OFF_IRQ_MASK, 32'h0); wt(2);
        chk(32'(irq_o), 32'h0);
        wr(OFF_IRQ_STAT, 32'hf);
        r = $urandom;
        wr(OFF_DIV, {20'h0, r[11:0]});
        rd(OFF_DIV, {20'h0, r[11:0]});
        period(int'(r[3:0]) + 1);
        v = 16'($urandom);
        wr(OFF_MSTOP, 32'(v)); wt(2);
        chk(32'(module_run), {16'h0, ~v});
        wr(OFF_MSTOP, 32'h0);
        wr(OFF_WAKE_EN, 32'h1);
        wr(OFF_SNOOZE_EN, 32'h4);
        irq <= 16'h4; wt(5);
        rd(OFF_STATE, 32'h0);
        irq <= 16'h0;
        wr(OFF_LPCTRL, 32'h100); wt(2);
        rd(OFF_STATE, 32'h1);
        ncore(1'b1, 1'b1);
        chk(32'(module_run), 32'hffff);
        irq[$urandom % 16] <= 1'b1; wt(5);
        rd(OFF_STATE, 32'h0);
        irq <= 16'h0;
        sleep_req <= 1'b1; wt(5);
        rd(OFF_STATE, 32'h1);
        sleep_req <= 1'b0; rrq <= 6'h1; wt(5);
        rrq <= 6'h0;
        rd(OFF_STATE, 32'h0);
        wr(OFF_LPCTRL, 32'h101); wt(2);
        rd(OFF_STATE, 32'h2);
        chk({31'h0, io_hold}, 32'h1);
        chk(32'(osc_enable), 32'h0);
        chk(32'(module_run), 32'h0);
        ncore(1'b0, 1'b0);
        irq <= 16'h2; wt(5);
        rd(OFF_STATE, 32'h2);
        irq <= 16'h4; wt(5);
        rd(OFF_STATE, 32'h4);
        chk(32'(module_run), 32'h4);
        ncore(1'b1, 1'b0);
        irq <= 16'h0; wt(5);
        rd(OFF_STATE, 32'h2);
        irq <= 16'h1; wt(5);
        rd(OFF_STATE, 32'h0);
        irq <= 16'h0;
        period(int'(r[3:0]) + 1);
        chk(32'(osc_enable), 32'h1 << SRC_RESET);
        wr(OFF_LPCTRL, 32'h102); wt(3);
        chk({30'h0, core_pwr, mem_pwr}, 32'h0);
        chk(32'(osc_enable), 32'h0);
        rrq <= 6'h10; wt(6);
        rrq <= 6'h0; wt(2);
        chk({31'h0, core_pwr}, 32'h1);
        rd(OFF_STATE, 32'h0);
        rd(OFF_IRQ_STAT, 32'h7);
        wt(2);
        wrap_up();
    end
endmodule
bind lpc_ctrl lpc_ctrl_checker chk_i (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_ack_o(wb_ack_o), .reset_request(reset_request), .system_core_clock_en(system_core_clock_en),
    .osc_enable(osc_enable), .core_power_on(core_power_on), .memory_power_on(memory_power_on),
    .io_hold(io_hold), .irq_o(irq_o));
